// [verilog/pec_dev.sv]
`timescale 1ns/1ns
`include "pec_defs.svh"
// Summary of operation
// - answer as slave at address A0h
// - master sends address, mem address, count
// - memory address explicitly second byte
// - read count one to 128 bytes; device takes any 8-bit count, zero sends the CRC byte alone
// - device returns data then CRC byte
// - master NACKs CRC then STOP
// - read CRC over mem address, count, data
// - CRC-8 polynomial x8+x2+x+1
// - master checks CRC, clears ok on mismatch
// - write: address, mem address, count
// - device ACKs each written data byte
// - checked write carries exactly four bytes
// - master sends CRC then add-on byte
// - ACK add-on if CRC matches and count is four, else NACK
// - write CRC over mem address, count, data
// - master STOPs, final ACK is success
// - NACK own address while programming row
// - MSB first, first byte is address
module pec_dev (
   // system
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // bus
   pec_if.dev bus,
   // memory side
   output logic [7:0] mem_addr_o,
   input wire logic [7:0] mem_rdata_i,
   output logic mem_rd_o,
   output logic [31:0] row_data_o,
   output logic row_wr_o,
   output logic busy_o,
   output logic crc_err_o
);
   // ==========================================
   // pin synchronisers and edge detection
   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic scl_d;
   logic sda_d;
   always_ff @(posedge clk_i) begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
   end
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   assign scl_rise = scl_s[1] && !scl_d;
   assign scl_fall = !scl_s[1] && scl_d;
   assign start_c = scl_s[1] && scl_d && sda_d && !sda_s[1];
   assign stop_c = scl_s[1] && scl_d && !sda_d && sda_s[1];
   // ==========================================
   // transfer state
   pec_pkg::pec_dev_e state;
   logic [2:0] bitn;
   logic [7:0] shreg;
   logic [3:0] idx;
   logic rw;
   logic [7:0] cnt;
   logic [7:0] crc;
   logic [7:0] crc_rx;
   logic ack_ok;
   logic [31:0] wbuf;
   logic wr_pend;
   logic [15:0] busy_cnt;
   logic sda_lo;
   logic byte_in;
   // received byte at 8th rising edge
   logic [7:0] rx_byte;
   assign rx_byte = {shreg[6:0], sda_s[1]};
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= pec_pkg::PEC_IDLE;
         bitn <= 3'h0;
         shreg <= 8'h00;
         idx <= 4'h0;
         rw <= 1'b0;
         cnt <= 8'h00;
         crc <= `PEC_CRC_INIT;
         crc_rx <= 8'h00;
         ack_ok <= 1'b0;
         wbuf <= 32'h0000_0000;
         wr_pend <= 1'b0;
         sda_lo <= 1'b0;
         byte_in <= 1'b0;
         mem_addr_o <= 8'h00;
         mem_rd_o <= 1'b0;
         row_wr_o <= 1'b0;
         row_data_o <= 32'h0000_0000;
         crc_err_o <= 1'b0;
      end else begin
         mem_rd_o <= 1'b0;
         row_wr_o <= 1'b0;
         if (start_c) begin
            state <= pec_pkg::PEC_ADDR;
            bitn <= 3'h0;
            byte_in <= 1'b0;
            sda_lo <= 1'b0;
         end else if (stop_c) begin
            state <= pec_pkg::PEC_IDLE;
            sda_lo <= 1'b0;
            if (wr_pend) begin
               row_wr_o <= 1'b1;
               row_data_o <= wbuf;
            end
            wr_pend <= 1'b0;
         end else begin
            case (state)
               pec_pkg::PEC_ADDR, pec_pkg::PEC_RX: begin
                  if (scl_rise) begin
                     shreg <= rx_byte;
                     bitn <= bitn + 3'h1;
                     byte_in <= bitn == 3'h7;
                  end
                  // a byte is handled only once its eighth bit is in
                  if (scl_fall && byte_in) begin
                     byte_in <= 1'b0;
                     if (state == pec_pkg::PEC_ADDR) begin
                        if (shreg[7:1] == 7'(`PEC_SLAVE_ADDR >> 1) && busy_cnt == 16'h0000) begin
                           rw <= shreg[0];
                           sda_lo <= 1'b1;
                           state <= pec_pkg::PEC_ADDR_ACK;
                           if (shreg[0]) begin
                              mem_rd_o <= 1'b1;
                           end else begin
                              idx <= 4'h0;
                              crc <= `PEC_CRC_INIT;
                              wr_pend <= 1'b0;
                           end
                        end else begin
                           state <= pec_pkg::PEC_SKIP;
                        end
                     end else begin
                        state <= pec_pkg::PEC_RX_ACK;
                        sda_lo <= 1'b1;
                        idx <= idx + 4'h1;
                        if (idx == 4'h0) begin
                           mem_addr_o <= shreg;
                           crc <= pec_pkg::pec_crc8(crc, shreg);
                        end else if (idx == 4'h1) begin
                           cnt <= shreg;
                           crc <= pec_pkg::pec_crc8(crc, shreg);
                        end else if (idx < 4'h2 + `PEC_WR_COUNT) begin
                           wbuf <= {wbuf[23:0], shreg};
                           crc <= pec_pkg::pec_crc8(crc, shreg);
                        end else if (idx == 4'h2 + `PEC_WR_COUNT) begin
                           crc_rx <= shreg;
                        end else begin
                           ack_ok <= (crc_rx == crc) && cnt == `PEC_WR_COUNT;
                           sda_lo <= (crc_rx == crc) && cnt == `PEC_WR_COUNT;
                           wr_pend <= (crc_rx == crc) && cnt == `PEC_WR_COUNT;
                           crc_err_o <= crc_rx != crc;
                        end
                     end
                  end
               end
               pec_pkg::PEC_ADDR_ACK, pec_pkg::PEC_RX_ACK: begin
                  if (scl_fall) begin
                     if (rw) begin
                        // data until count reached, then CRC
                        state <= pec_pkg::PEC_TX;
                        shreg <= (cnt == 8'h00) ? crc : mem_rdata_i;
                        sda_lo <= (cnt == 8'h00) ? !crc[7] : !mem_rdata_i[7];
                        if (cnt != 8'h00) begin
                           crc <= pec_pkg::pec_crc8(crc, mem_rdata_i);
                           cnt <= cnt - 8'h01;
                           mem_addr_o <= mem_addr_o + 8'h01;
                        end
                     end else begin
                        state <= pec_pkg::PEC_RX;
                        sda_lo <= 1'b0;
                     end
                     bitn <= 3'h0;
                  end
               end
               pec_pkg::PEC_TX: begin
                  if (scl_fall) begin
                     bitn <= bitn + 3'h1;
                     if (bitn == 3'h7) begin
                        sda_lo <= 1'b0;
                        state <= pec_pkg::PEC_TX_ACK;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_lo <= !shreg[6];
                     end
                  end
               end
               pec_pkg::PEC_TX_ACK: begin
                  if (scl_rise) begin
                     if (sda_s[1]) begin
                        state <= pec_pkg::PEC_SKIP;
                     end else begin
                        state <= pec_pkg::PEC_RX_ACK;
                        mem_rd_o <= 1'b1;
                     end
                  end
               end
               pec_pkg::PEC_SKIP: begin
                  sda_lo <= 1'b0;
               end
               default: begin
                  state <= pec_pkg::PEC_IDLE;
               end
            endcase
         end
      end
   end
   // ==========================================
   // nonvolatile programming busy window
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         busy_cnt <= 16'h0000;
      end else if (row_wr_o) begin
         busy_cnt <= `PEC_NV_BUSY_CYCLES;
      end else if (busy_cnt != 16'h0000) begin
         busy_cnt <= busy_cnt - 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= row_wr_o || busy_cnt > 16'h0001;
      end
   end
   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = sda_lo;
endmodule

// [pkg/pec_defs.svh]
`ifndef PEC_DEFS_SVH
`define PEC_DEFS_SVH
`define PEC_SLAVE_ADDR 8'hA0
`define PEC_CRC_POLY 8'h07
`define PEC_CRC_INIT 8'h00
`define PEC_RD_MAX 8'h80
`define PEC_WR_COUNT 8'h04
`define PEC_NV_BUSY_CYCLES 16'h0100
`define PEC_SCL_HALF 8'h04
`endif

// [pkg/pec_pkg.sv]
`include "pec_defs.svh"
package pec_pkg;
   typedef enum {PEC_IDLE, PEC_ADDR, PEC_ADDR_ACK, PEC_RX, PEC_RX_ACK, PEC_TX, PEC_TX_ACK, PEC_SKIP} pec_dev_e;
   typedef enum {PEC_M_IDLE, PEC_M_START, PEC_M_BIT, PEC_M_ACK, PEC_M_RSTART, PEC_M_STOP, PEC_M_DONE} pec_host_e;
   function automatic logic [7:0] pec_crc8(input logic [7:0] crc, input logic [7:0] d);
      logic [7:0] c;
      c = crc ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ `PEC_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction
endpackage

// [pkg/pec_if.sv]
`timescale 1ns/1ns
interface pec_if;
   logic scl;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic sda_host_o;
   logic sda_host_oe;
   wire sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
   modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface

// [verilog/pec_host.sv]
`timescale 1ns/1ns
`include "pec_defs.svh"
module pec_host (
   // system
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // bus
   pec_if.host bus,
   // user command
   input wire logic go_i,
   input wire logic rd_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] count_i,
   input wire logic [31:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic rdata_vld_o,
   output logic done_o,
   output logic ok_o
);
   // ==========================================
   // SCL divider and SDA sampling
   logic [7:0] div;
   logic tick;
   logic [1:0] sda_s;
   always_ff @(posedge clk_i) begin
      sda_s <= {sda_s[0], bus.sda};
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         div <= 8'h00;
      end else begin
         div <= (div == `PEC_SCL_HALF) ? 8'h00 : div + 8'h01;
      end
   end
   assign tick = div == `PEC_SCL_HALF;
   // ==========================================
   // sequencer: each data bit is three ticks (two low, one high), each ack bit two (low, high)
   pec_pkg::pec_host_e state;
   logic scl;
   logic sda_lo;
   logic [7:0] sh;
   logic [2:0] bitn;
   logic [3:0] idx;
   logic [7:0] left;
   logic [7:0] crc;
   logic [7:0] rxb;
   logic phase;
   logic tx;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state <= pec_pkg::PEC_M_IDLE;
         scl <= 1'b1;
         sda_lo <= 1'b0;
         sh <= 8'h00;
         bitn <= 3'h0;
         idx <= 4'h0;
         left <= 8'h00;
         crc <= `PEC_CRC_INIT;
         rxb <= 8'h00;
         phase <= 1'b0;
         tx <= 1'b1;
         rdata_o <= 8'h00;
         rdata_vld_o <= 1'b0;
         done_o <= 1'b0;
         ok_o <= 1'b0;
      end else begin
         rdata_vld_o <= 1'b0;
         done_o <= 1'b0;
         case (state)
            pec_pkg::PEC_M_IDLE: begin
               scl <= 1'b1;
               sda_lo <= 1'b0;
               if (go_i) begin
                  state <= pec_pkg::PEC_M_START;
                  idx <= 4'h0;
                  crc <= `PEC_CRC_INIT;
                  left <= count_i;
                  ok_o <= 1'b1;
               end
            end
            pec_pkg::PEC_M_START: if (tick) begin
               phase <= !phase;
               if (!phase) begin
                  scl <= 1'b1;
                  sda_lo <= 1'b1;
               end else begin
                  scl <= 1'b0;
                  tx <= 1'b1;
                  // the repeated start of a checked read carries the read bit
                  sh <= (idx != 4'h0) ? (`PEC_SLAVE_ADDR | 8'h01) : `PEC_SLAVE_ADDR;
                  sda_lo <= 1'b1;
                  bitn <= 3'h0;
                  state <= pec_pkg::PEC_M_BIT;
               end
            end
            // raise scl with sda released, then start as usual
            pec_pkg::PEC_M_RSTART: if (tick) begin
               scl <= 1'b1;
               sda_lo <= 1'b0;
               state <= pec_pkg::PEC_M_START;
            end
            pec_pkg::PEC_M_BIT: if (tick) begin
               phase <= !phase;
               if (!phase) begin
                  sda_lo <= tx ? !sh[7] : 1'b0;
               end else if (!scl) begin
                  scl <= 1'b1;
                  phase <= 1'b1;
                  rxb <= {rxb[6:0], sda_s[1]};
               end else begin
                  scl <= 1'b0;
                  sh <= {sh[6:0], 1'b0};
                  bitn <= bitn + 3'h1;
                  if (bitn == 3'h7) begin
                     state <= pec_pkg::PEC_M_ACK;
                     // reading: ACK data, NACK the CRC byte
                     sda_lo <= !tx && left != 8'h00;
                  end
               end
            end
            pec_pkg::PEC_M_ACK: if (tick) begin
               phase <= !phase;
               if (!phase) begin
                  scl <= 1'b1;
               end else begin
                  scl <= 1'b0;
                  sda_lo <= 1'b0;
                  idx <= idx + 4'h1;
                  if (tx && sda_s[1] && (idx != 4'h8 || rd_i)) begin
                     ok_o <= 1'b0;
                     state <= pec_pkg::PEC_M_STOP;
                  end else if (tx && rd_i && idx == 4'h2) begin
                     state <= pec_pkg::PEC_M_RSTART;
                  end else if (!tx) begin
                     if (left == 8'h00) begin
                        ok_o <= rxb == crc;
                        state <= pec_pkg::PEC_M_STOP;
                     end else begin
                        rdata_o <= rxb;
                        rdata_vld_o <= 1'b1;
                        crc <= pec_pkg::pec_crc8(crc, rxb);
                        left <= left - 8'h01;
                        state <= pec_pkg::PEC_M_BIT;
                     end
                  end else if (rd_i && idx == 4'h3) begin
                     tx <= 1'b0;
                     state <= pec_pkg::PEC_M_BIT;
                  end else if (!rd_i && idx == 4'h8) begin
                     ok_o <= !sda_s[1];
                     state <= pec_pkg::PEC_M_STOP;
                  end else begin
                     state <= pec_pkg::PEC_M_BIT;
                     sh <= (idx == 4'h0) ? addr_i : (idx == 4'h1) ? count_i :
                        (idx < 4'h6) ? wdata_i[8'd31 - {idx - 4'h2, 3'b000} -: 8] :
                        (idx == 4'h6) ? crc : 8'h00;
                     if (idx < 4'h6) begin
                        crc <= pec_pkg::pec_crc8(crc, (idx == 4'h0) ? addr_i : (idx == 4'h1) ? count_i :
                           wdata_i[8'd31 - {idx - 4'h2, 3'b000} -: 8]);
                     end
                  end
                  bitn <= 3'h0;
               end
            end
            // sda low while scl low, then scl high, then release sda
            pec_pkg::PEC_M_STOP: if (tick) begin
               phase <= !phase;
               if (!phase) begin
                  sda_lo <= 1'b1;
               end else if (!scl) begin
                  scl <= 1'b1;
                  phase <= 1'b1;
               end else begin
                  sda_lo <= 1'b0;
                  state <= pec_pkg::PEC_M_DONE;
               end
            end
            pec_pkg::PEC_M_DONE: begin
               done_o <= 1'b1;
               state <= pec_pkg::PEC_M_IDLE;
            end
            default: begin
               state <= pec_pkg::PEC_M_IDLE;
            end
         endcase
      end
   end
   assign bus.scl = scl;
   assign bus.sda_host_o = 1'b0;
   assign bus.sda_host_oe = sda_lo;
endmodule

// [verif/pec_properties.sv]
`timescale 1ns/1ns
// ==========================================
// bus protocol checks on the joined link
module pec_properties (
   // system
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // bus
   input wire logic scl,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda
);
   logic [7:0] hi_cnt;

   // counts clocks of scl high, saturating
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !scl) begin
         hi_cnt <= 8'h00;
      end else if (hi_cnt != 8'hFF) begin
         hi_cnt <= hi_cnt + 8'h01;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_idle_after_reset: assert property ($fell(sys_rst_i) |-> scl && sda && !sda_dev_oe && !sda_host_oe)
      else $error("bus not idle after reset");
   a_dev_moves_low: assert property ($changed(sda_dev_oe) |-> !scl)
      else $error("device moved sda while scl high");
   a_dev_open_drain: assert property (sda_dev_oe |-> !sda_dev_o)
      else $error("device drives sda high");
   a_host_open_drain: assert property (sda_host_oe |-> !sda_host_o)
      else $error("host drives sda high");
   a_no_contention: assert property (scl && sda_host_oe |-> !sda_dev_oe)
      else $error("both ends drive sda while scl high");
   a_scl_low_span: assert property ($fell(scl) |-> !scl [*5] ##[1:20] scl)
      else $error("scl low phase out of range");
   a_scl_high_span: assert property ($rose(scl) |-> scl [*5])
      else $error("scl high phase too short");
   a_idle_released: assert property (hi_cnt > 8'h0F && !sda_host_oe |-> sda && !sda_dev_oe)
      else $error("sda held low on idle bus");
endmodule

// [verif/pec_bench.sv]
`timescale 1ns/1ns
// ==========================================
// bench top
module pec_bench;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic go, rd, rdata_vld, done, ok, ack, dack;
   logic [7:0] addr, count, rdata, mem_addr_a, mem_addr_b, first_b;
   logic [31:0] wdata, row_a, row_b;
   logic row_wr_a, row_wr_b, busy_a, busy_b, err_a, err_b;
   int fail_count = 0;
   int checks_done = 0;
   int rows_a = 0;
   int rows_b = 0;
   logic [7:0] rq[$];

   pec_if bus_a();
   pec_if bus_b();

   always #25 clk_i = ~clk_i;

   pec_host pec_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_a.host), .go_i(go), .rd_i(rd),
      .addr_i(addr), .count_i(count), .wdata_i(wdata), .rdata_o(rdata), .rdata_vld_o(rdata_vld),
      .done_o(done), .ok_o(ok));
   pec_dev pec_dev_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_a.dev), .mem_addr_o(mem_addr_a),
      .mem_rdata_i(mem_addr_a ^ 8'hC3), .mem_rd_o(), .row_data_o(row_a), .row_wr_o(row_wr_a),
      .busy_o(busy_a), .crc_err_o(err_a));
   // second device, driven by hand to break the rules on purpose
   pec_dev pec_dev_fault_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus_b.dev), .mem_addr_o(mem_addr_b),
      .mem_rdata_i(mem_addr_b ^ 8'hC3), .mem_rd_o(), .row_data_o(row_b), .row_wr_o(row_wr_b),
      .busy_o(busy_b), .crc_err_o(err_b));
   pec_properties pec_properties_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl(bus_a.scl),
      .sda_dev_o(bus_a.sda_dev_o), .sda_dev_oe(bus_a.sda_dev_oe), .sda_host_o(bus_a.sda_host_o),
      .sda_host_oe(bus_a.sda_host_oe), .sda(bus_a.sda));

   always @(posedge clk_i) begin
      if (rdata_vld === 1'b1) rq.push_back(rdata);
      if (row_wr_a === 1'b1) rows_a++;
      if (row_wr_b === 1'b1) rows_b++;
   end

   // ==========================================
   // helpers
   task chk(input logic c, input string m);
      checks_done++;
      if (c !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task conclude;
      $display("mismatches %0d, checks %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task half;
      repeat (5) @(negedge clk_i);
   endtask

   // serial crc, msb first, no reflection
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int k = 7; k >= 0; k--) r = (r[7] ^ d[k]) ? ((r << 1) ^ 8'h07) : (r << 1);
      return r;
   endfunction

   // every start is followed by the slave address
   always @(negedge bus_a.sda) begin
      // sda may fall in the same step as scl: let scl settle first
      #1;
      if (bus_a.scl === 1'b1) begin
         for (int k = 0; k < 8; k++) begin
            @(posedge bus_a.scl);
            first_b = {first_b[6:0], bus_a.sda};
         end
         chk(first_b[7:1] === 7'h50, "first byte not the slave address");
      end
   end

   task run(input logic r, input logic [7:0] a, input logic [7:0] n, input logic [31:0] w);
      int t;
      rq.delete();
      rd = r;
      addr = a;
      count = n;
      wdata = w;
      go = 1'b1;
      @(negedge clk_i);
      go = 1'b0;
      t = 0;
      while (done !== 1'b1 && t < 20000) begin
         @(negedge clk_i);
         t++;
      end
      chk(t < 20000, "host transfer hung");
   endtask

   task bb_byte(input logic [7:0] b, output logic a);
      for (int k = 7; k >= 0; k--) begin
         @(negedge clk_i);
         bus_b.sda_host_oe = !b[k];
         half();
         bus_b.scl = 1'b1;
         half();
         bus_b.scl = 1'b0;
      end
      @(negedge clk_i);
      bus_b.sda_host_oe = 1'b0;
      half();
      bus_b.scl = 1'b1;
      half();
      a = (bus_b.sda === 1'b0);
      bus_b.scl = 1'b0;
   endtask

   task bb_start;
      bus_b.sda_host_oe = 1'b1;
      half();
      bus_b.scl = 1'b0;
   endtask

   task bb_stop;
      @(negedge clk_i);
      bus_b.sda_host_oe = 1'b1;
      half();
      bus_b.scl = 1'b1;
      half();
      bus_b.sda_host_oe = 1'b0;
      half();
   endtask

   // ==========================================
   // scenarios
   task t_read(input logic [7:0] a, input logic [7:0] n);
      run(1'b1, a, n, 32'h0000_0000);
      chk(ok === 1'b1, "read checksum rejected");
      chk(rq.size() == int'(n), "read byte count wrong");
      foreach (rq[i]) chk(rq[i] === ((a + 8'(i)) ^ 8'hC3), "read data wrong");
   endtask

   task t_write_busy;
      int r0;
      int t;
      r0 = rows_a;
      run(1'b0, 8'h40, 8'h04, 32'hDEAD_BEEF);
      // stop is seen through the synchroniser, the row strobe lands a few cycles later
      repeat (5) @(negedge clk_i);
      chk(ok === 1'b1, "checked write refused");
      chk(rows_a == r0 + 1 && row_a === 32'hDEAD_BEEF, "row not written");
      chk(err_a === 1'b0 && busy_a === 1'b1, "no programming window");
      run(1'b1, 8'h40, 8'h01, 32'h0000_0000);
      chk(ok === 1'b0, "address acked while programming");
      t = 0;
      while (busy_a !== 1'b0 && t < 1000) begin
         @(negedge clk_i);
         t++;
      end
      chk(t < 1000, "programming never ends");
   endtask

   task bb_write(input logic [7:0] bad);
      logic [7:0] s[7];
      logic [7:0] c;
      int r0;
      s = '{8'hA0, 8'h20, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
      c = 8'h00;
      for (int k = 1; k < 7; k++) c = crc8(c, s[k]);
      r0 = rows_b;
      dack = 1'b1;
      bb_start();
      for (int k = 0; k < 7; k++) begin
         bb_byte(s[k], ack);
         dack = dack & ack;
      end
      bb_byte(c ^ bad, ack);
      bb_byte(8'h00, ack);
      bb_stop();
      repeat (2) @(negedge clk_i);
      chk(dack === 1'b1, "data byte not acked");
      chk(ack === (bad == 8'h00), "final acknowledge wrong");
      chk(rows_b == r0 + ((bad == 8'h00) ? 1 : 0), "row write count wrong");
      chk(err_b === (bad != 8'h00), "checksum error flag wrong");
      if (bad == 8'h00) chk(row_b === 32'h1122_3344, "row data wrong");
   endtask

   task t_fault;
      bb_start();
      bb_byte(8'hA2, ack);
      bb_stop();
      chk(ack === 1'b0, "foreign address acked");
      bb_write(8'h01);
      bb_write(8'h00);
   endtask

   // ==========================================
   // main sequence
   initial begin
      go = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      count = 8'h00;
      wdata = 32'h0000_0000;
      bus_b.scl = 1'b1;
      bus_b.sda_host_o = 1'b0;
      bus_b.sda_host_oe = 1'b0;
      repeat (5) @(negedge clk_i);
      sys_rst_i = 1'b0;
      @(negedge clk_i);
      t_read(8'h10, 8'h03);
      t_read(8'h00, 8'h80);
      t_write_busy();
      t_read(8'h40, 8'h01);
      t_fault();
      conclude();
   end

   initial begin
      #3000000;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end
endmodule
